// ===== common/dirf_regs.svh
// Register offsets, field positions, reset values and timing figures
// Assumes inclusion by both design files; definitions only
`ifndef DIRF_REGS_SVH
`define DIRF_REGS_SVH
// Register byte offsets
`define DIRF_CTRL_OFF     12'h000
`define DIRF_FUNC_OFF     12'h004
`define DIRF_TRIM_OFF     12'h008
`define DIRF_JOG_OFF      12'h00c
`define DIRF_REF_OFF      12'h010
`define DIRF_STAT_OFF     12'h014
`define DIRF_OUT_OFF      12'h018
`define DIRF_IRQ_STAT_OFF 12'h01c
`define DIRF_IRQ_EN_OFF   12'h020
`define DIRF_IRQ_CLR_OFF  12'h024
// Control register fields
`define DIRF_CTRL_FSRC_LSB 0
`define DIRF_CTRL_RSRC_LSB 4
`define DIRF_CTRL_STOP_LSB 8
`define DIRF_CTRL_RUN_BIT  12
// Input function codes
`define DIRF_FN_OPSRC     8'h02
`define DIRF_FN_RAMP_HOLD 8'h0a
`define DIRF_FN_UP        8'h10
`define DIRF_FN_DOWN      8'h11
`define DIRF_FN_FORWARD_JOG_INPUT      8'h12
`define DIRF_FN_REVERSE_JOG_INPUT      8'h13
`define DIRF_FN_TRIM_INC  8'h1c
`define DIRF_FN_TRIM_DEC  8'h1d
`define DIRF_FN_SAMPLE    8'h1e
// Frequency source codes for the two analog inputs and the option source
`define DIRF_FSRC_ANALOG  4'h1
`define DIRF_FSRC_ANALOG2 4'h2
`define DIRF_FSRC_OPTION  4'h3
// Reset values; frequencies in 0.01 Hz units
`define DIRF_JOG_RESET    16'h0258
`define DIRF_TRIM_RESET   16'h0000
// Timing
`define DIRF_CLK_HZ       100000000
`define DIRF_TICK_MS      1
`define DIRF_SAMPLE_MS    100
`define DIRF_CONFLICT_MS  500
// Interrupt event bits
`define DIRF_EV_CONFLICT  0
`define DIRF_EV_HELD      1
`define DIRF_EV_JOGSTOP   2
`endif

// ===== common/dirf_pkg.sv
// Types shared by the input reference block
// Assumes nothing beyond the constants header
package dirf_pkg;
  typedef enum logic [2:0]
  {
    DIRF_SH_IDLE = 3'b001,
    DIRF_SH_WAIT = 3'b010,
    DIRF_SH_HELD = 3'b100
  } dirf_sh_type;
endpackage

// ===== design/dirf_tick.sv
// Millisecond enable divider
// Assumes a single free-running clock at the rate given by parameter
`timescale 1ns/1ps
`include "dirf_regs.svh"
module dirf_tick
#(
  parameter int DIV = (`DIRF_CLK_HZ / 1000) * `DIRF_TICK_MS
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // One-cycle enable every millisecond
  output logic tick
);
  logic [31:0] count;

  // Free counter; tick is one cycle wide
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= 32'h0;
      tick <= 1'b0;
    end
    else if (count == 32'(DIV - 1))
    begin
      count <= 32'h0;
      tick <= 1'b1;
    end
    else
    begin
      count <= count + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // dirf_tick

// ===== design/dirf_core.sv
// Input reference functions: trim, sample/hold, source switch, jog
// Assumes terminal and analog inputs synchronous to pclk; APB slave
//
// Notes on behaviour
// [R1] Trim acts only when reference is above zero and from an analog input
// [R2] Trimmed reference below zero is clamped to zero
// [R3] Trim increase without decrease, or reverse, raises conflict alarm
// [R4] Code 1c adds step, 1d subtracts, both or neither hold reference
// [R5] Sample/hold input on: sample analog reference 100 ms later, hold it
// [R6] Sample/hold with ramp hold, up/down or trim raises conflict alarm
// [R7] Sample/hold released before 100 ms captures nothing
// [R8] Outside party keeps sample/hold closed at least 100 ms
// [R9] Held reference cleared at power-up
// [R10] Code 2 on selects local sources, off selects option card
// [R11] Source selection change ignored while a run command is active
// [R12] Configurer sets local frequency and run sources not equal to 3
// [R13] Code 12 runs forward at jog frequency, code 13 in reverse
// [R14] Jog inputs start operation without a separate run command
// [R15] Jog frequency resets to 6.00 Hz and may change while running
// [R16] Jog frequency has priority over every other reference source
// [R17] Both jog inputs on 500 ms or longer stop with chosen method
// [R18] Delays timed by millisecond tick; counts restart when condition ends
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "dirf_regs.svh"
module dirf_core
  import dirf_pkg::*;
#(
  parameter int NTERM = 5,
  parameter int FW = 16,
  parameter int SAMPLE_MS = `DIRF_SAMPLE_MS,
  parameter int CONFLICT_MS = `DIRF_CONFLICT_MS,
  parameter int CLK_HZ = `DIRF_CLK_HZ
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Terminals and analog references
  input wire logic [NTERM-1:0] multi_input_terminals,
  input wire logic [FW-1:0] analog_input_one,
  input wire logic [FW-1:0] analog_input_two,
  input wire logic [FW-1:0] local_freq_ref,
  input wire logic [FW-1:0] option_freq_ref,
  input wire logic local_run_cmd,
  input wire logic option_run_cmd,
  // Drive command outputs
  output logic [FW-1:0] freq_ref,
  output logic run_cmd,
  output logic run_reverse,
  output logic stop_request,
  output logic [3:0] stop_method_select,
  output logic config_conflict_alarm,
  output logic irq
);
  // Settings written by software
  logic [3:0] freq_source_select;
  logic [3:0] run_source_select;
  logic sw_run;
  logic [8*NTERM-1:0] input_function_select;
  logic [FW-1:0] trim_step_amount;
  logic [FW-1:0] jog_freq_setting;
  logic [2:0] irq_stat;
  logic [2:0] irq_en;
  // Internal state
  dirf_sh_type sh_state;
  logic [FW-1:0] held_ref;
  logic [9:0] sh_count;
  logic [9:0] jc_count;
  logic jog_stopped;
  logic use_local;
  logic tick;
  logic [NTERM-1:0] act_trim_inc, act_trim_dec, act_sample, act_opsrc;
  logic [NTERM-1:0] act_forward_jog_input, act_reverse_jog_input, act_ramp, act_updn;
  logic trim_inc, trim_dec, sample_in, opsrc_in, forward_jog_input, reverse_jog_input;
  logic has_inc, has_dec, has_sample, has_other;
  logic [FW-1:0] base_ref, trimmed;
  logic src_analog;
  logic [FW-1:0] analog_sel;
  logic sample_done;
  logic jog_both;
  logic jog_conflict_done;
  logic wr, rd;
  logic [2:0] events;
  localparam int FNW = (8 * NTERM > 32) ? 32 : 8 * NTERM; // One bus word

  // Millisecond enable
  dirf_tick #(.DIV(CLK_HZ / 1000 * `DIRF_TICK_MS)) u_tick
  (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  // Function code of one terminal; used for every assignment test
  function automatic logic is_fn(input logic [8*NTERM-1:0] sel,
                                 input int idx, input logic [7:0] code);
    is_fn = (sel[8*idx +: 8] == code);
  endfunction

  // Per-terminal decode of assigned functions
  genvar gi;
  generate
    for (gi = 0; gi < NTERM; gi++)
    begin : g_term
      assign act_trim_inc[gi] = is_fn(input_function_select, gi,
                                      `DIRF_FN_TRIM_INC);
      assign act_trim_dec[gi] = is_fn(input_function_select, gi,
                                      `DIRF_FN_TRIM_DEC);
      assign act_sample[gi] = is_fn(input_function_select, gi,
                                    `DIRF_FN_SAMPLE);
      assign act_opsrc[gi] = is_fn(input_function_select, gi,
                                   `DIRF_FN_OPSRC);
      assign act_forward_jog_input[gi] = is_fn(input_function_select, gi,
                                  `DIRF_FN_FORWARD_JOG_INPUT);
      assign act_reverse_jog_input[gi] = is_fn(input_function_select, gi,
                                  `DIRF_FN_REVERSE_JOG_INPUT);
      assign act_ramp[gi] = is_fn(input_function_select, gi,
                                  `DIRF_FN_RAMP_HOLD);
      assign act_updn[gi] = is_fn(input_function_select, gi, `DIRF_FN_UP)
                          | is_fn(input_function_select, gi, `DIRF_FN_DOWN);
    end
  endgenerate

  // Terminal levels routed to functions, and which functions are assigned at all
  assign trim_inc = |(act_trim_inc & multi_input_terminals);
  assign trim_dec = |(act_trim_dec & multi_input_terminals);
  assign sample_in = |(act_sample & multi_input_terminals);
  assign opsrc_in = |(act_opsrc & multi_input_terminals);
  assign forward_jog_input = |(act_forward_jog_input & multi_input_terminals);
  assign reverse_jog_input = |(act_reverse_jog_input & multi_input_terminals);
  assign has_inc = |act_trim_inc;
  assign has_dec = |act_trim_dec;
  assign has_sample = |act_sample;
  assign has_other = |act_ramp | |act_updn | has_inc | has_dec;

  // Configuration check
  assign config_conflict_alarm = (has_inc != has_dec) // R3
                               | (has_sample & has_other); // R6

  // Operation source; latched only while no run is active
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      use_local <= 1'b1;
    else if (!run_cmd)
      use_local <= opsrc_in | ~|act_opsrc; // R10 R11
  end

  // Base reference from the selected source
  assign src_analog = use_local && (freq_source_select == `DIRF_FSRC_ANALOG
                      || freq_source_select == `DIRF_FSRC_ANALOG2);
  assign analog_sel = (freq_source_select == `DIRF_FSRC_ANALOG2) ?
                      analog_input_two : analog_input_one;
  assign base_ref = !use_local ? option_freq_ref : // R10
                    src_analog ? analog_sel : local_freq_ref;

  // Trim applied to analog reference above zero, clamped at zero
  always_comb
  begin
    trimmed = base_ref;
    if (src_analog && base_ref != '0) // R1
    begin
      if (trim_inc && !trim_dec) // R4
        trimmed = base_ref + trim_step_amount;
      else if (trim_dec && !trim_inc)
        trimmed = (base_ref > trim_step_amount) ? // R2
                  base_ref - trim_step_amount : '0;
    end
  end

  // Sample/hold qualifier; one tick extra so a part millisecond never counts
  assign sample_done = (sh_count == 10'(SAMPLE_MS + 1));
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh_state <= DIRF_SH_IDLE;
      sh_count <= 10'h0;
      held_ref <= '0; // R9
    end
    else
    begin
      unique case (sh_state)
        DIRF_SH_IDLE:
        begin
          sh_count <= 10'h0;
          if (sample_in)
            sh_state <= DIRF_SH_WAIT;
        end
        DIRF_SH_WAIT:
        begin
          if (!sample_in)
          begin
            sh_state <= DIRF_SH_IDLE; // R7 R18
            sh_count <= 10'h0;
          end
          else if (sample_done)
          begin
            held_ref <= base_ref; // R5
            sh_state <= DIRF_SH_HELD;
          end
          else if (tick)
            sh_count <= sh_count + 10'h1; // R18
        end
        DIRF_SH_HELD:
        begin
          sh_count <= 10'h0;
          if (!sample_in)
            sh_state <= DIRF_SH_IDLE;
        end
      endcase
    end
  end

  // Jog conflict timer, restarts when either jog input drops
  assign jog_both = forward_jog_input & reverse_jog_input;
  assign jog_conflict_done = (jc_count == 10'(CONFLICT_MS + 1));
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      jc_count <= 10'h0;
      jog_stopped <= 1'b0;
    end
    else if (!jog_both)
    begin
      jc_count <= 10'h0; // R18
      jog_stopped <= 1'b0;
    end
    else if (jog_conflict_done)
      jog_stopped <= 1'b1; // R17
    else if (tick)
      jc_count <= jc_count + 10'h1;
  end

  // Drive command outputs from flip-flops; jog wins over all sources
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freq_ref <= '0;
      run_cmd <= 1'b0;
      run_reverse <= 1'b0;
      stop_request <= 1'b0;
    end
    else
    begin
      stop_request <= jog_stopped;
      if (jog_stopped)
      begin
        run_cmd <= 1'b0; // R17
        freq_ref <= '0;
      end
      else if (forward_jog_input || reverse_jog_input)
      begin
        freq_ref <= jog_freq_setting; // R13 R16
        run_cmd <= 1'b1; // R14
        run_reverse <= reverse_jog_input & ~forward_jog_input;
      end
      else
      begin
        freq_ref <= (sh_state == DIRF_SH_HELD) ? held_ref : trimmed;
        run_cmd <= use_local ? (sw_run | local_run_cmd) : option_run_cmd;
        run_reverse <= 1'b0;
      end
    end
  end

  // APB: zero wait states, no error answer
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~pwrite;

  // Software settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freq_source_select <= 4'h0;
      run_source_select <= 4'h0;
      stop_method_select <= 4'h0;
      sw_run <= 1'b0;
      input_function_select <= '0;
      trim_step_amount <= `DIRF_TRIM_RESET;
      jog_freq_setting <= `DIRF_JOG_RESET; // R15
      irq_en <= 3'h0;
    end
    else if (wr)
    begin
      unique case (paddr)
        `DIRF_CTRL_OFF:
        begin
          freq_source_select <= pwdata[`DIRF_CTRL_FSRC_LSB +: 4];
          run_source_select <= pwdata[`DIRF_CTRL_RSRC_LSB +: 4];
          stop_method_select <= pwdata[`DIRF_CTRL_STOP_LSB +: 4];
          sw_run <= pwdata[`DIRF_CTRL_RUN_BIT];
        end
        `DIRF_FUNC_OFF: input_function_select[FNW-1:0] <= pwdata[FNW-1:0];
        `DIRF_TRIM_OFF: trim_step_amount <= pwdata[FW-1:0];
        `DIRF_JOG_OFF: jog_freq_setting <= pwdata[FW-1:0]; // R15
        `DIRF_IRQ_EN_OFF: irq_en <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  assign events = {jog_stopped & ~stop_request,
                   sample_done & sample_in & (sh_state == DIRF_SH_WAIT),
                   config_conflict_alarm};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat <= 3'h0;
    else if (wr && paddr == `DIRF_IRQ_CLR_OFF)
      irq_stat <= (irq_stat & ~pwdata[2:0]) | events;
    else
      irq_stat <= irq_stat | events;
  end
  assign irq = |(irq_stat & irq_en);

  // Read mux
  always_comb
  begin
    prdata = 32'h0;
    if (rd)
    begin
      unique case (paddr)
        `DIRF_CTRL_OFF: prdata = {19'h0, sw_run, stop_method_select,
                                  run_source_select, freq_source_select};
        `DIRF_FUNC_OFF: prdata[FNW-1:0] = input_function_select[FNW-1:0];
        `DIRF_TRIM_OFF: prdata[FW-1:0] = trim_step_amount;
        `DIRF_JOG_OFF: prdata[FW-1:0] = jog_freq_setting;
        `DIRF_REF_OFF: prdata[FW-1:0] = held_ref;
        `DIRF_STAT_OFF: prdata[7:0] = {use_local, jog_stopped, forward_jog_input, reverse_jog_input,
                                       config_conflict_alarm, sh_state};
        `DIRF_OUT_OFF: prdata[FW-1:0] = freq_ref;
        `DIRF_IRQ_STAT_OFF: prdata[2:0] = irq_stat;
        `DIRF_IRQ_EN_OFF: prdata[2:0] = irq_en;
        default: prdata = 32'h0;
      endcase
    end
  end
endmodule // dirf_core

// ===== test/dirf_contacts.sv
// Model of the contacts and analog source wired to the drive terminals
// Assumes the bench names the wanted levels; contacts move on clock edges
`timescale 1ns/1ps
module dirf_contacts
(
  // Clock
  input wire logic pclk,
  // Levels asked for by the bench
  input wire logic [3:0] want,
  input wire logic [15:0] want_ana,
  // Lines into the drive
  output logic [3:0] multi_input_terminals = 4'h0,
  output logic [15:0] analog_input_one = 16'h0
);
  // Settle right after an edge so the drive never sees a half-made change
  always @(posedge pclk)
  begin
    multi_input_terminals <= want;
    analog_input_one <= want_ana;
  end
endmodule // dirf_contacts

// ===== test/dirf_core_sva.sv
// Checker for the input reference block, attached to dirf_core by bind
// Assumes zero-wait writes and a millisecond of CLK_HZ / 1000 clocks
`timescale 1ns/1ps
`include "dirf_regs.svh"
module dirf_core_sva
#(
  parameter int NTERM = 4,
  parameter int SAMPLE_MS = 2,
  parameter int CONFLICT_MS = 2,
  parameter int CLK_HZ = 100000000
)
(
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Terminals and drive commands
  input wire logic [NTERM-1:0] multi_input_terminals,
  input wire logic [15:0] freq_ref,
  input wire logic run_cmd,
  input wire logic run_reverse,
  input wire logic stop_request,
  input wire logic [3:0] stop_method_select,
  input wire logic config_conflict_alarm
);
  localparam int MSCYC = CLK_HZ / 1000 * `DIRF_TICK_MS;
  localparam logic [NTERM-1:0] ALL = '1;
  logic [31:0] func;
  logic [31:0] ctrl;
  logic [15:0] jog;
  logic fj, rj, sh, alarm_exp;
  int both_cnt;
  int sh_cnt;
  function automatic logic has(input logic [31:0] f, input logic [7:0] c,
                               input logic [NTERM-1:0] m);
    has = 1'b0;
    for (int i = 0; i < NTERM; i++)
      has |= m[i] && f[8*i +: 8] == c;
  endfunction
  // Shadow copies, so expectations never lean on the design's registers
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      func <= 32'h0;
      ctrl <= 32'h0;
      jog <= 16'h0258;
    end
    else if (psel && penable && pwrite)
    begin
      if (paddr == `DIRF_FUNC_OFF)
        func <= pwdata;
      if (paddr == `DIRF_CTRL_OFF)
        ctrl <= pwdata;
      if (paddr == `DIRF_JOG_OFF)
        jog <= pwdata[15:0];
    end
  // Active functions seen at the terminals, and the expected configuration alarm
  assign fj = has(func, 8'h12, multi_input_terminals);
  assign rj = has(func, 8'h13, multi_input_terminals);
  assign sh = has(func, 8'h1e, multi_input_terminals) && !alarm_exp;
  assign alarm_exp = (has(func, 8'h1c, ALL) ^ has(func, 8'h1d, ALL)) |
    (has(func, 8'h1e, ALL) & (has(func, 8'h0a, ALL) | has(func, 8'h10, ALL)
    | has(func, 8'h11, ALL) | has(func, 8'h1c, ALL) | has(func, 8'h1d, ALL)));
  // Run lengths of the two timed conditions; both restart when broken
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      both_cnt <= 0;
      sh_cnt <= 0;
    end
    else
    begin
      both_cnt <= (fj && rj) ? both_cnt + 1 : 0;
      sh_cnt <= sh ? sh_cnt + 1 : 0;
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_fwd;
    (fj && !rj) [*2];
  endsequence
  sequence s_rev;
    (!fj && rj) [*2];
  endsequence
  sequence s_quiet;
    (!fj && !rj) [*4] ##0 (sh_cnt > (SAMPLE_MS + 1) * MSCYC + 4);
  endsequence
  a_alarm_cfg:
    assert property (config_conflict_alarm == alarm_exp) else $error("alarm");
  a_jog_fwd:
    assert property (s_fwd |=> run_cmd && !run_reverse &&
      freq_ref == $past(jog)) else $error("forward jog");
  a_jog_rev:
    assert property (s_rev |=> run_cmd && run_reverse &&
      freq_ref == $past(jog)) else $error("reverse jog");
  a_stop_early:
    assert property ($rose(stop_request) |-> $past(fj && rj, 2) &&
      $past(both_cnt, 2) >= CONFLICT_MS * MSCYC) else $error("early stop");
  a_stop_late:
    assert property (both_cnt == (CONFLICT_MS + 1) * MSCYC + 4 |->
      stop_request) else $error("late stop");
  a_stop_run:
    assert property (stop_request && $past(fj && rj) |-> !run_cmd)
      else $error("run while stopped");
  a_stop_method:
    assert property (stop_method_select == ctrl[11:8]) else $error("method");
  a_hold_stable:
    assert property (s_quiet |-> $stable(freq_ref)) else $error("hold moved");
  a_reset_zero:
    assert property ($rose(presetn) |-> freq_ref == 16'h0) else $error("rst");
endmodule // dirf_core_sva
bind dirf_core dirf_core_sva #(.NTERM(NTERM), .SAMPLE_MS(SAMPLE_MS),
  .CONFLICT_MS(CONFLICT_MS), .CLK_HZ(CLK_HZ)) i_dirf_core_sva (.*);

// ===== test/tb_dirf_core.sv
// Self-checking bench for the input reference block
// Assumes a 100 MHz clock, a shortened millisecond and short timed functions
`timescale 1ns/1ps
`include "dirf_regs.svh"
module tb_dirf_core;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, lrun = 1'b0, orun = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, w;
  logic pready, pslverr, run_cmd, rev, stop, alarm, irq;
  logic [3:0] want = 4'h0, term, stop_sel, fs;
  logic [15:0] ana = 16'h0, lref = 16'h0, oref = 16'h0, a1, freq_ref;
  logic [15:0] a, s, l, o, b, ana2 = 16'h0;
  logic [1:0] t;
  logic [31:0] cfg [6] = '{32'h1c, 32'h1d1c, 32'h1d1c1e, 32'h0a1e,
    32'h11101e, 32'h1e};
  logic alm [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  int err_count = 0;
  int cmp_count = 0;
  dirf_contacts i_dirf_contacts (.pclk(pclk), .want(want), .want_ana(ana),
    .multi_input_terminals(term), .analog_input_one(a1));
  dirf_core #(.NTERM(4), .SAMPLE_MS(2), .CONFLICT_MS(2),
    .CLK_HZ(100000)) i_dirf_core
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .multi_input_terminals(term),
    .analog_input_one(a1), .analog_input_two(ana2), .local_freq_ref(lref),
    .option_freq_ref(oref), .local_run_cmd(lrun), .option_run_cmd(orun),
    .freq_ref(freq_ref), .run_cmd(run_cmd), .run_reverse(rev),
    .stop_request(stop), .stop_method_select(stop_sel),
    .config_conflict_alarm(alarm), .irq(irq)
  );
  // Free-running clock
  initial
    forever #5 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus transfer; an idle edge follows so strobes never toggle twice
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [15:0] trim_exp(input logic [15:0] x, y,
                                           input logic [1:0] k);
    if (x == 16'h0 || k[0] == k[1])
      return x;
    if (k[0])
      return x + y;
    return (x > y) ? x - y : 16'h0;
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Cut a hang short
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    end_of_test();
  end
  // Main sequence
  initial
  begin
    void'($urandom(16));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `DIRF_JOG_OFF, 0);
    chk(rd, 32'h258);
    apb(0, `DIRF_REF_OFF, 0);
    chk(rd, 32'h0);
    apb(0, 12'h100, 0);
    chk(rd, 32'h0);
    $display("reset test done");
    foreach (cfg[i])
    begin
      apb(1, `DIRF_FUNC_OFF, cfg[i]);
      chk(32'(alarm), 32'(alm[i]));
    end
    // Raise, mask and clear the alarm event
    apb(1, `DIRF_FUNC_OFF, 32'h1c);
    apb(1, `DIRF_IRQ_EN_OFF, 32'h1);
    chk(32'(irq), 32'h1);
    apb(1, `DIRF_IRQ_EN_OFF, 32'h0);
    chk(32'(irq), 32'h0);
    apb(1, `DIRF_FUNC_OFF, 32'h0);
    apb(1, `DIRF_IRQ_CLR_OFF, 32'h7);
    apb(0, `DIRF_IRQ_STAT_OFF, 0);
    chk(rd, 32'h0);
    apb(1, `DIRF_IRQ_EN_OFF, 32'h7);
    chk(32'(irq), 32'h0);
    $display("alarm test done");
    apb(1, `DIRF_FUNC_OFF, 32'h1d1c);
    for (int i = 0; i < 40; i++)
    begin
      s = 16'($urandom_range(500, 1));
      a = (i == 0) ? 16'h0 : (i == 1) ? s : 16'($urandom_range(1000));
      t = (i < 2) ? 2'(i + 1) : 2'($urandom);
      fs = (i > 1) ? 4'($urandom_range(2)) : 4'h1;
      l = 16'($urandom);
      b = 16'($urandom_range(1000));
      w = {20'h0, 4'($urandom), 4'h1, fs};
      apb(1, `DIRF_CTRL_OFF, w);
      chk(32'(stop_sel), 32'(w[11:8]));
      apb(1, `DIRF_TRIM_OFF, {16'h0, s});
      ana <= a;
      ana2 <= b;
      lref <= l;
      want <= {2'b00, t};
      repeat (4) @(posedge pclk);
      o = (fs == 4'h0) ? l : trim_exp(fs[1] ? b : a, s, t);
      chk(32'(freq_ref), 32'(o));
    end
    $display("trim test done");
    l = 16'($urandom);
    o = ~l;
    lref <= l;
    oref <= o;
    apb(1, `DIRF_FUNC_OFF, 32'h02000000);
    apb(1, `DIRF_CTRL_OFF, 32'h0);
    want <= 4'h8;
    repeat (4) @(posedge pclk);
    chk(32'(freq_ref), 32'(l));
    want <= 4'h0;
    repeat (4) @(posedge pclk);
    chk(32'(freq_ref), 32'(o));
    want <= 4'h8;
    repeat (4) @(posedge pclk);
    lrun <= 1'b1;
    orun <= 1'b1;
    apb(1, `DIRF_CTRL_OFF, 32'h1000);
    chk(32'(run_cmd), 32'h1);
    want <= 4'h0;
    repeat (4) @(posedge pclk);
    chk(32'(freq_ref), 32'(l));
    lrun <= 1'b0;
    orun <= 1'b0;
    apb(1, `DIRF_CTRL_OFF, 32'h0);
    repeat (4) @(posedge pclk);
    chk(32'(freq_ref), 32'(o));
    $display("source test done");
    apb(1, `DIRF_FUNC_OFF, 32'h0013121e);
    apb(1, `DIRF_CTRL_OFF, 32'h211);
    a = 16'($urandom_range(4000, 1));
    ana <= a;
    want <= 4'h1;
    repeat (150) @(posedge pclk);
    want <= 4'h0;
    repeat (4) @(posedge pclk);
    apb(0, `DIRF_REF_OFF, 0);
    chk(rd, 32'h0);
    chk(32'(freq_ref), 32'(a));
    a = a + 16'h1;
    ana <= a;
    want <= 4'h1;
    repeat (1000) @(posedge pclk);
    want <= 4'h3;
    repeat (4) @(posedge pclk);
    chk(32'(freq_ref), 32'h258);
    chk({30'h0, run_cmd, rev}, 32'h2);
    apb(1, `DIRF_JOG_OFF, 32'h3e8);
    repeat (3) @(posedge pclk);
    chk(32'(freq_ref), 32'h3e8);
    want <= 4'h5;
    repeat (4) @(posedge pclk);
    chk({30'h0, run_cmd, rev}, 32'h3);
    want <= 4'h7;
    for (int n = 0; n < 2000 && stop !== 1'b1; n++)
      @(posedge pclk);
    chk({30'h0, stop, run_cmd}, 32'h2);
    rd = 32'h0;
    while (rd[1] !== 1'b1)
      apb(0, `DIRF_IRQ_STAT_OFF, 0);
    ana <= a ^ 16'h55;
    want <= 4'h1;
    repeat (4) @(posedge pclk);
    chk(32'(stop), 32'h0);
    chk(32'(freq_ref), 32'(a));
    apb(0, `DIRF_REF_OFF, 0);
    chk(rd, 32'(a));
    $display("hold and jog test done");
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `DIRF_REF_OFF, 0);
    chk(rd, 32'h0);
    $display("second reset test done");
    end_of_test();
  end
endmodule // tb_dirf_core
